// [flash_pin_defines.svh]
// constants of the serial flash pin control front end
`ifndef FLASH_PIN_DEFINES_SVH
`define FLASH_PIN_DEFINES_SVH

// pin configuration codes
`define PIN_CFG_DEDICATED_RESET 2'h0
`define PIN_CFG_SHARED_RESET 2'h1
`define PIN_CFG_SHARED_PAUSE 2'h2
`define PIN_CFG_LAST 2'h2

// field positions
`define STATUS_WRITE_DISABLE_BIT 7
`define CFG_RESET_PAUSE_BIT 4

// reset values
`define STATUS_WRITE_DISABLE_RESET 1'h0
`define DQ_OE_N_IDLE 4'hF
`define DQ_OUT_IDLE 4'h0

// lane masks
`define LANES_X1_IN 4'h1
`define LANES_X1_OUT 4'h2
`define LANES_X2 4'h3
`define LANES_X4 4'hF

`endif

// [flash_pin_pkg.sv]
// types of the serial flash pin control front end
`default_nettype none
package flash_pin_pkg;

  typedef enum logic [1:0] {
    extended_protocol,
    dual_line_protocol,
    quad_line_protocol
  } protocol_t;

  typedef enum logic [1:0] {
    single_transfer_rate_x1,
    width_x2,
    width_x4
  } width_t;

  typedef enum logic [1:0] {
    LinkStandby,
    LinkActive,
    LinkPaused,
    LinkReset
  } link_t;

  typedef struct packed {
    logic clkMeta;
    logic clkSync;
    logic clkPrev;
    logic selMeta;
    logic selSync;
    logic selPrev;
    logic rstMeta;
    logic rstSync;
    logic [3:0] dqMeta;
    logic [3:0] dqSync;
    logic sawFall;
    link_t link;
    logic standby;
    logic [3:0] rxBits;
    logic rxValid;
    logic [3:0] dqOut;
    logic [3:0] dqOeN;
    logic wsDone;
    logic wsRefused;
    logic statusLocked;
  } state_t;

endpackage
`default_nettype wire

// [serial_flash_pin_control.sv]
// pin-level front end of a multi-line serial flash: select, clock, pins
`include "flash_pin_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_flash_pin_control #(
  parameter logic [1:0] PIN_CFG = `PIN_CFG_SHARED_PAUSE
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // flash pins
  input wire logic sclk,
  input wire logic selN,
  input wire logic resetPinN,
  input wire logic [3:0] dqIn,
  output logic [3:0] dqOut,
  output logic [3:0] dqOeN,
  // configuration
  input wire flash_pin_pkg::protocol_t protocol,
  input wire logic dtrEnable,
  input wire logic [15:0] nvConfig,
  input wire logic [7:0] evConfig,
  input wire logic [7:0] statusReg,
  // command context from the decoder
  input wire logic cmdPhase,
  input wire flash_pin_pkg::width_t cmdWidth,
  input wire logic internalBusy,
  input wire logic txEnable,
  input wire logic [3:0] txBits,
  input wire logic statusWriteReq,
  // captured data and status
  output logic [3:0] rxBits,
  output logic rxValid,
  output logic standby,
  output logic active,
  output logic paused,
  output logic inReset,
  output logic statusWriteDone,
  output logic statusWriteRefused,
  output logic statusLocked
);

  if (PIN_CFG > `PIN_CFG_LAST)
  begin : g_bad_cfg
    $error("PIN_CFG out of range");
  end

  flash_pin_pkg::state_t st;
  flash_pin_pkg::state_t next_st;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic flash_pin_pkg::width_t effWidth(
    input flash_pin_pkg::protocol_t p,
    input flash_pin_pkg::width_t w
  );
    if (p == flash_pin_pkg::quad_line_protocol)
    begin
      return flash_pin_pkg::width_x4;
    end
    if (p == flash_pin_pkg::dual_line_protocol)
    begin
      return flash_pin_pkg::width_x2;
    end
    return w;
  endfunction

  function automatic logic [3:0] inMask(input flash_pin_pkg::width_t w);
    unique case (w)
      flash_pin_pkg::single_transfer_rate_x1: return `LANES_X1_IN;
      flash_pin_pkg::width_x2: return `LANES_X2;
      flash_pin_pkg::width_x4: return `LANES_X4;
      default: return `LANES_X1_IN;
    endcase
  endfunction

  function automatic logic [3:0] outMask(input flash_pin_pkg::width_t w);
    unique case (w)
      flash_pin_pkg::single_transfer_rate_x1: return `LANES_X1_OUT;
      flash_pin_pkg::width_x2: return `LANES_X2;
      flash_pin_pkg::width_x4: return `LANES_X4;
      default: return `LANES_X1_OUT;
    endcase
  endfunction

  function automatic logic [3:0] placeTx(
    input flash_pin_pkg::width_t w,
    input logic [3:0] b
  );
    unique case (w)
      flash_pin_pkg::single_transfer_rate_x1: return {2'h0, b[0], 1'h0};
      flash_pin_pkg::width_x2: return {2'h0, b[1:0]};
      flash_pin_pkg::width_x4: return b;
      default: return 4'h0;
    endcase
  endfunction

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  logic rise;
  logic fall;
  logic quadProto;
  logic cfgOff;
  logic resetHit;
  logic pauseHit;
  logic takeEdge;
  logic driveEdge;
  logic wpIsData;
  flash_pin_pkg::width_t w;

  always_comb
  begin
    next_st = st;
    next_st.clkMeta = sclk;
    next_st.clkSync = st.clkMeta;
    next_st.clkPrev = st.clkSync;
    next_st.selMeta = selN;
    next_st.selSync = st.selMeta;
    next_st.selPrev = st.selSync;
    next_st.rstMeta = resetPinN;
    next_st.rstSync = st.rstMeta;
    next_st.dqMeta = dqIn;
    next_st.dqSync = st.dqMeta;
    next_st.rxValid = 1'h0;
    next_st.wsDone = 1'h0;
    next_st.wsRefused = 1'h0;
    rise = st.clkSync & ~st.clkPrev;
    fall = ~st.clkSync & st.clkPrev;
    quadProto = (protocol == flash_pin_pkg::quad_line_protocol);
    w = effWidth(protocol, cmdWidth);
    // disabling bit: a zero in either register turns the function off
    cfgOff = ~nvConfig[`CFG_RESET_PAUSE_BIT] |
      ~evConfig[`CFG_RESET_PAUSE_BIT];
    if (PIN_CFG == `PIN_CFG_DEDICATED_RESET)
    begin
      resetHit = ~cfgOff & ~st.rstSync;
    end
    else if (PIN_CFG == `PIN_CFG_SHARED_RESET)
    begin
      resetHit = ~cfgOff & ~quadProto & ~st.selSync &
        ~st.dqSync[3];
    end
    else
    begin
      resetHit = 1'h0;
    end
    pauseHit = (PIN_CFG == `PIN_CFG_SHARED_PAUSE) & ~cfgOff & ~quadProto &
      ~dtrEnable & ~st.selSync & ~st.dqSync[3];
    // commands only on rising; data per transfer rate
    takeEdge = (cmdPhase | ~dtrEnable) ? rise : (rise | fall);
    driveEdge = dtrEnable ? (rise | fall) : fall;
    wpIsData = quadProto | (w == flash_pin_pkg::width_x4);
    if (st.selPrev & ~st.selSync)
    begin
      next_st.sawFall = 1'h1;
    end
    if (resetHit)
    begin
      next_st.link = flash_pin_pkg::LinkReset;
      next_st.sawFall = 1'h0;
    end
    else if (st.selSync)
    begin
      next_st.link = flash_pin_pkg::LinkStandby;
    end
    else if (~st.sawFall & ~(st.selPrev & ~st.selSync))
    begin
      next_st.link = flash_pin_pkg::LinkStandby;
    end
    else if (pauseHit)
    begin
      next_st.link = flash_pin_pkg::LinkPaused;
    end
    else
    begin
      next_st.link = flash_pin_pkg::LinkActive;
    end
    // standby only once internal cycles have completed
    next_st.standby = (next_st.link == flash_pin_pkg::LinkStandby) &
      ~internalBusy;
    if (next_st.link == flash_pin_pkg::LinkActive)
    begin
      if (takeEdge)
      begin
        next_st.rxBits = st.dqSync & inMask(w);
        next_st.rxValid = 1'h1;
      end
      if (txEnable)
      begin
        next_st.dqOeN = ~outMask(w);
        if (driveEdge)
        begin
          next_st.dqOut = placeTx(w, txBits);
        end
      end
      else
      begin
        next_st.dqOeN = `DQ_OE_N_IDLE;
      end
    end
    else
    begin
      next_st.dqOeN = `DQ_OE_N_IDLE;
    end
    if (next_st.link == flash_pin_pkg::LinkReset)
    begin
      next_st.dqOut = `DQ_OUT_IDLE;
      next_st.rxBits = 4'h0;
    end
    // protection holds until write-protect returns high
    next_st.statusLocked = statusReg[`STATUS_WRITE_DISABLE_BIT] &
      ~st.dqSync[2] & ~wpIsData;
    if (statusWriteReq & (st.link == flash_pin_pkg::LinkActive))
    begin
      next_st.wsDone = ~next_st.statusLocked;
      next_st.wsRefused = next_st.statusLocked;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '{clkMeta: 1'h0, clkSync: 1'h0, clkPrev: 1'h0,
        selMeta: 1'h1, selSync: 1'h1, selPrev: 1'h1,
        rstMeta: 1'h1, rstSync: 1'h1, dqMeta: 4'hF, dqSync: 4'hF,
        sawFall: 1'h0, link: flash_pin_pkg::LinkStandby,
        standby: 1'h1, rxBits: 4'h0, rxValid: 1'h0,
        dqOut: `DQ_OUT_IDLE, dqOeN: `DQ_OE_N_IDLE,
        wsDone: 1'h0, wsRefused: 1'h0,
        statusLocked: `STATUS_WRITE_DISABLE_RESET};
    end
    else
    begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign dqOut = st.dqOut;
  assign dqOeN = st.dqOeN;
  assign rxBits = st.rxBits;
  assign rxValid = st.rxValid;
  assign standby = st.standby;
  assign active = (st.link == flash_pin_pkg::LinkActive);
  assign paused = (st.link == flash_pin_pkg::LinkPaused);
  assign inReset = (st.link == flash_pin_pkg::LinkReset);
  assign statusWriteDone = st.wsDone;
  assign statusWriteRefused = st.wsRefused;
  assign statusLocked = st.statusLocked;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  standby_released_a: assert property (
    !active |-> dqOeN == `DQ_OE_N_IDLE)
    else $error("lines driven outside active");

  select_high_a: assert property (
    $rose(st.selSync) && !resetHit |=> !active)
    else $error("active after select rose");

  busy_blocks_standby_a: assert property (
    internalBusy |=> !standby)
    else $error("standby while internal cycle runs");

  select_low_a: assert property (
    active |-> !$past(st.selSync) && st.sawFall)
    else $error("active without select low");

  dtr_off_rx_a: assert property (
    rxValid && !dtrEnable |-> $past(st.clkSync) && !$past(st.clkPrev))
    else $error("single rate capture off rising edge");

  cmd_rise_a: assert property (
    rxValid && $past(cmdPhase) |-> $past(st.clkSync))
    else $error("command bit off rising edge");

  x1_lanes_a: assert property (
    active && $past(txEnable) &&
    $past(w) == flash_pin_pkg::single_transfer_rate_x1 |-> dqOeN == 4'hD)
    else $error("x1 output not on line one only");

  reset_release_a: assert property (
    resetHit |=> inReset && dqOeN == `DQ_OE_N_IDLE)
    else $error("reset not taken");

  pause_off_dtr_a: assert property (
    dtrEnable && $stable(dtrEnable) |=> !paused)
    else $error("pause while double rate");

  wp_lock_a: assert property (
    statusWriteReq && active && next_st.statusLocked |=>
    statusWriteRefused && !statusWriteDone)
    else $error("status write not refused");

  c_active: cover property ($rose(active) ##[1:200] rxValid);
  c_pause: cover property ($rose(paused) ##[1:200] active);
  c_refuse: cover property (statusWriteRefused);
  c_reset: cover property ($fell(inReset));

endmodule // serial_flash_pin_control

`default_nettype wire

// [flash_host_model.sv]
// host side model: select, serial clock and line drivers
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // flash pins
  output logic sclk,
  output logic selN,
  output logic [3:0] dq
);
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  initial
  begin
    sclk = 1'h0;
    selN = 1'h1;
    dq = 4'hC;
  end
  task automatic select();
  begin
    #37 selN = 1'h0;
  end
  endtask
  // clock stays low outside frames
  task automatic shift(input logic [3:0] b);
  begin
    dq = b;
    #80 sclk = 1'h1;
    #80 sclk = 1'h0;
  end
  endtask
  // released data lines 0 and 1 do not keep their last level; lines 2 and 3 do
  task automatic deselect();
  begin
    #43 selN = 1'h1;
    dq[1:0] = ~dq[1:0];
  end
  endtask
endmodule // flash_host_model
`default_nettype wire

// [test_serial_flash_pin_control.sv]
// self-checking bench of the serial flash pin front end
`include "flash_pin_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_pin_control;
  typedef struct packed {
    flash_pin_pkg::protocol_t p;
    flash_pin_pkg::width_t w;
    logic [3:0] d;
    logic [3:0] rx;
  } row_t;
  logic core_clk, rst, sclk, selN, rstPinN, dtr, busy, txEn, wsReq, cmdPh;
  logic [3:0] dq, dqOut, dqOeN, txBits, rxBits;
  logic [15:0] nvCfg;
  logic [7:0] evCfg, stReg;
  flash_pin_pkg::protocol_t proto;
  flash_pin_pkg::width_t width;
  logic rxValid, standby, active, paused, inReset, wsDone, wsRef, locked;
  logic gotDone, gotRef;
  int fails = 0;
  int checks = 0;
  row_t rows [3];
  flash_host_model host (.sclk(sclk), .selN(selN), .dq(dq));
  serial_flash_pin_control dut_u (.core_clk(core_clk), .rst(rst),
    .sclk(sclk), .selN(selN), .resetPinN(rstPinN), .dqIn(dq),
    .dqOut(dqOut), .dqOeN(dqOeN), .protocol(proto), .dtrEnable(dtr),
    .nvConfig(nvCfg), .evConfig(evCfg), .statusReg(stReg),
    .cmdPhase(cmdPh), .cmdWidth(width), .internalBusy(busy),
    .txEnable(txEn), .txBits(txBits), .statusWriteReq(wsReq),
    .rxBits(rxBits), .rxValid(rxValid), .standby(standby),
    .active(active), .paused(paused), .inReset(inReset),
    .statusWriteDone(wsDone), .statusWriteRefused(wsRef),
    .statusLocked(locked));
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [3:0] seen, exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic settle();
  begin
    repeat (6) @(negedge core_clk);
  end
  endtask
  task automatic tryWrite();
  begin
    gotDone = 1'h0;
    gotRef = 1'h0;
    @(negedge core_clk) wsReq = 1'h1;
    @(negedge core_clk) wsReq = 1'h0;
    repeat (3)
    begin
      gotDone = gotDone | wsDone;
      gotRef = gotRef | wsRef;
      @(negedge core_clk);
    end
  end
  endtask
  task automatic tally_and_finish();
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    rst = 1'h1;
    rstPinN = 1'h1;
    dtr = 1'h0;
    busy = 1'h0;
    txEn = 1'h0;
    wsReq = 1'h0;
    cmdPh = 1'h0;
    txBits = 4'h1;
    nvCfg = 16'hFFFF;
    evCfg = 8'hFF;
    stReg = 8'h00;
    proto = flash_pin_pkg::extended_protocol;
    width = flash_pin_pkg::single_transfer_rate_x1;
    rows[0] = '{flash_pin_pkg::extended_protocol,
      flash_pin_pkg::single_transfer_rate_x1, 4'hF, 4'h1};
    rows[1] = '{flash_pin_pkg::dual_line_protocol,
      flash_pin_pkg::width_x2, 4'hE, 4'h2};
    rows[2] = '{flash_pin_pkg::quad_line_protocol,
      flash_pin_pkg::width_x4, 4'h5, 4'h5};
    repeat (20) @(negedge core_clk);
    check("reset oe", dqOeN, `DQ_OE_N_IDLE);
    check("reset standby", 4'(standby), 4'h1);
    rst = 1'h0;
    $display("reset test ended");
    foreach (rows[i])
    begin
      proto = rows[i].p;
      width = rows[i].w;
      cmdPh = 1'h1;
      host.select();
      settle();
      check("active", 4'(active), 4'h1);
      host.shift(rows[i].d);
      check("rx", rxBits, rows[i].rx);
      host.deselect();
      settle();
      check("standby", 4'(standby), 4'h1);
      check("idle oe", dqOeN, `DQ_OE_N_IDLE);
    end
    $display("capture rows ended");
    host.dq = 4'hC;
    proto = flash_pin_pkg::extended_protocol;
    width = flash_pin_pkg::single_transfer_rate_x1;
    cmdPh = 1'h0;
    txEn = 1'h1;
    host.select();
    settle();
    check("x1 oe", dqOeN, 4'hD);
    host.shift(4'hF);
    settle();
    check("x1 out", 4'(dqOut[1]), 4'h1);
    host.dq[3] = 1'h0;
    settle();
    check("paused", 4'(paused), 4'h1);
    check("pause oe", dqOeN, `DQ_OE_N_IDLE);
    check("pause no reset", 4'(inReset), 4'h0);
    evCfg = 8'hEF;
    settle();
    check("pause off", 4'(paused), 4'h0);
    evCfg = 8'hFF;
    dtr = 1'h1;
    settle();
    check("pause dtr", 4'(paused), 4'h0);
    dtr = 1'h0;
    host.dq[3] = 1'h1;
    proto = flash_pin_pkg::quad_line_protocol;
    width = flash_pin_pkg::width_x4;
    settle();
    check("x4 oe", dqOeN, 4'h0);
    host.deselect();
    settle();
    check("tx released", dqOeN, `DQ_OE_N_IDLE);
    txEn = 1'h0;
    $display("drive and pause test ended");
    proto = flash_pin_pkg::extended_protocol;
    width = flash_pin_pkg::single_transfer_rate_x1;
    stReg = 8'h80;
    host.dq[2] = 1'h0;
    host.select();
    settle();
    check("locked", 4'(locked), 4'h1);
    tryWrite();
    check("refused", 4'(gotRef), 4'h1);
    check("not done", 4'(gotDone), 4'h0);
    host.dq[2] = 1'h1;
    settle();
    check("unlocked", 4'(locked), 4'h0);
    tryWrite();
    check("done", 4'(gotDone), 4'h1);
    stReg = 8'h00;
    host.dq[2] = 1'h0;
    settle();
    tryWrite();
    check("bit7 clear", 4'(gotDone), 4'h1);
    busy = 1'h1;
    host.deselect();
    settle();
    check("busy standby", 4'(standby), 4'h0);
    busy = 1'h0;
    settle();
    check("idle standby", 4'(standby), 4'h1);
    $display("status and busy test ended");
    tally_and_finish();
  end
endmodule // test_serial_flash_pin_control
`default_nettype wire
